// File: rtl/itg_consts.svh
`ifndef ITG_CONSTS_SVH
`define ITG_CONSTS_SVH

// queue geometry: stages between fetch and the head
`define ITG_QUEUE_DEPTH 3
// tag bit positions inside a two-bit tag
`define ITG_TAG_LO_BIT 0
`define ITG_TAG_HI_BIT 1
// reset values
`define ITG_TAG_NONE 2'h0
`define ITG_WORD_RESET 16'h0000

`endif

// File: rtl/itg_pkg.sv
package itg_pkg;
    // two-bit tag carried beside each program word: bit1 high byte, bit0 low byte
    typedef logic [1:0] itg_tag_t;
    // one program word in the queue
    typedef logic [15:0] itg_word_t;
    // tagging control states
    typedef enum logic [1:0] {
        ITG_IDLE,
        ITG_ARMED,
        ITG_BGND
    } itg_state_t;
endpackage

// File: rtl/itg_tag_sampler.sv
`timescale 1ns/10ps
`default_nettype none
`include "itg_consts.svh"
module itg_tag_sampler (
    input wire logic clk, // system clock
    input wire logic sys_rst, // sync reset, active high
    input wire logic external_bus_clock_fall, // falling edge of external bus clock
    input wire logic sample_en, // tagging armed
    input wire logic tag_low_input_n, // low tag pin level
    input wire logic tag_high_input_n, // high tag pin level
    output itg_pkg::itg_tag_t tag_q // latched tag
);
    import itg_pkg::*;
    // =====================================================
    // tag latch
    itg_tag_t tag_d; // next latched tag

    // capture pins at the bus clock falling edge only
    always_comb begin
        tag_d = tag_q;
        if (!sample_en) begin
            tag_d = `ITG_TAG_NONE; // no stale tag once disarmed
        end else if (external_bus_clock_fall) begin
            // each pin decodes on its own, active low
            tag_d[`ITG_TAG_LO_BIT] = ~tag_low_input_n;
            tag_d[`ITG_TAG_HI_BIT] = ~tag_high_input_n;
        end
    end

    // register only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tag_q <= `ITG_TAG_NONE;
        end else begin
            tag_q <= tag_d;
        end
    end
endmodule
`default_nettype wire

// File: rtl/itg_tag_queue.sv
`timescale 1ns/10ps
`default_nettype none
`include "itg_consts.svh"
module itg_tag_queue (
    input wire logic clk, // system clock
    input wire logic sys_rst, // sync reset, active high
    input wire logic flush, // drop queue contents
    input wire logic advance, // shift one stage toward head
    input wire itg_pkg::itg_word_t word_in, // fetched word
    input wire itg_pkg::itg_tag_t tag_in, // tag for fetched word
    output itg_pkg::itg_word_t head_word, // word at head
    output itg_pkg::itg_tag_t head_tag // tag at head
);
    import itg_pkg::*;
    // =====================================================
    // queue storage, tag travels with its word
    itg_word_t word_q [`ITG_QUEUE_DEPTH];
    itg_word_t word_d [`ITG_QUEUE_DEPTH];
    itg_tag_t tagv_q [`ITG_QUEUE_DEPTH];
    itg_tag_t tagv_d [`ITG_QUEUE_DEPTH];

    // next stage values
    always_comb begin
        // hold by default
        for (int i = 0; i < `ITG_QUEUE_DEPTH; i++) begin
            word_d[i] = word_q[i];
            tagv_d[i] = tagv_q[i];
        end
        if (flush) begin
            // flush beats advance
            for (int i = 0; i < `ITG_QUEUE_DEPTH; i++) begin
                word_d[i] = `ITG_WORD_RESET;
                tagv_d[i] = `ITG_TAG_NONE;
            end
        end else if (advance) begin
            // stage 0 apart, so no stage reads below index 0
            word_d[0] = word_in;
            tagv_d[0] = tag_in;
            for (int i = 1; i < `ITG_QUEUE_DEPTH; i++) begin
                // tag moves in lockstep with its word
                word_d[i] = word_q[i-1];
                tagv_d[i] = tagv_q[i-1];
            end
        end
    end

    // register stages
    genvar g;
    generate
        for (g = 0; g < `ITG_QUEUE_DEPTH; g++) begin : g_stage
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    word_q[g] <= `ITG_WORD_RESET;
                    tagv_q[g] <= `ITG_TAG_NONE;
                end else begin
                    word_q[g] <= word_d[g];
                    tagv_q[g] <= tagv_d[g];
                end
            end
        end
    endgenerate

    assign head_word = word_q[`ITG_QUEUE_DEPTH-1];
    assign head_tag = tagv_q[`ITG_QUEUE_DEPTH-1];
endmodule
`default_nettype wire

// File: rtl/itg_instruction_tagging.sv
`timescale 1ns/10ps
`default_nettype none
`include "itg_consts.svh"
module itg_instruction_tagging (
    input wire logic clk, // 100 MHz system clock
    input wire logic sys_rst, // sync reset, active high
    input wire logic external_bus_clock_in, // external bus clock level
    input wire logic tag_enable_command, // decoded tag-enable serial command pulse
    input wire logic serial_cmd_valid, // other serial command pulse
    input wire logic strobe_pin_in, // low-byte strobe / low tag pin level
    input wire logic background_pin_in, // background / high tag pin level
    input wire logic low_byte_strobe, // core low-byte strobe to drive
    input wire logic queue_advance, // queue shifts one stage
    input wire logic queue_flush, // queue discarded
    input wire itg_pkg::itg_word_t fetch_word, // fetched program word
    input wire logic break_on_program_control, // program-only break select
    input wire logic bkpt_match, // breakpoint comparator hit on fetch
    input wire logic head_execute, // head instruction about to execute
    input wire logic bgnd_exit, // background debug mode left
    output logic strobe_pin_out, // low-byte strobe drive
    output logic strobe_pin_oe_n, // strobe drive enable, low drives
    output logic tag_active, // tagging armed
    output logic serial_cmd_accept, // serial command passed on
    output logic background_debug_mode, // background mode active
    output logic enter_bgnd, // one-cycle entry pulse
    output itg_pkg::itg_word_t head_word, // word at queue head
    output itg_pkg::itg_tag_t head_tag // tag at queue head
);
    import itg_pkg::*;
    // =====================================================
    // bus clock edge detect (input taken as synchronous)
    logic external_bus_clock_q; // previous bus clock level
    logic external_bus_clock_d;
    logic external_bus_clock_fall; // falling edge this cycle

    always_comb begin
        external_bus_clock_d = external_bus_clock_in;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            external_bus_clock_q <= 1'h0;
        end else begin
            external_bus_clock_q <= external_bus_clock_d;
        end
    end

    assign external_bus_clock_fall = external_bus_clock_q & ~external_bus_clock_in;

    // =====================================================
    // control state machine
    itg_state_t state_q; // tagging state
    itg_state_t state_d;
    logic tag_active_q, tag_active_d;
    logic bdm_q, bdm_d;
    logic enter_q, enter_d;
    logic accept_q, accept_d;
    logic strobe_q, strobe_d;
    logic strobe_oe_n_q, strobe_oe_n_d;
    itg_tag_t sampled_tag; // latched pin tag
    itg_tag_t q_head_tag; // tag leaving queue
    itg_word_t q_head_word; // word leaving queue
    itg_tag_t fetch_tag; // tag merged with breakpoint
    logic head_hit; // tagged instruction at head

    // a breakpoint on an executable opcode rides the tag path,
    // so data and skipped opcodes never break
    always_comb begin
        fetch_tag = sampled_tag;
        if (break_on_program_control && bkpt_match) begin
            fetch_tag = 2'h3;
        end
    end

    // break only on an instruction actually at the head
    assign head_hit = (q_head_tag != `ITG_TAG_NONE) && head_execute;

    always_comb begin
        state_d = state_q;
        enter_d = 1'h0;
        accept_d = 1'h0;
        case (state_q)
            ITG_IDLE: begin
                accept_d = serial_cmd_valid;
                if (tag_enable_command) begin
                    state_d = ITG_ARMED;
                end
            end
            ITG_ARMED: begin
                // serial commands dropped while armed
                accept_d = 1'h0;
                if (head_hit) begin
                    state_d = ITG_BGND;
                    enter_d = 1'h1;
                end
            end
            ITG_BGND: begin
                accept_d = serial_cmd_valid;
                if (tag_enable_command) begin
                    state_d = ITG_ARMED;
                end else if (bgnd_exit) begin
                    state_d = ITG_IDLE;
                end
            end
            default: begin
                state_d = ITG_IDLE;
            end
        endcase
        // program breakpoint can also stop when not armed
        if (state_q == ITG_IDLE && head_hit) begin
            state_d = ITG_BGND;
            enter_d = 1'h1;
        end
        // no mode input gates any of this
        tag_active_d = (state_d == ITG_ARMED);
        bdm_d = (state_d == ITG_BGND);
        // pin is strobe output unless armed as tag input
        strobe_d = low_byte_strobe;
        strobe_oe_n_d = tag_active_d;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= ITG_IDLE;
            tag_active_q <= 1'h0;
            bdm_q <= 1'h0;
            enter_q <= 1'h0;
            accept_q <= 1'h0;
            strobe_q <= 1'h0;
            strobe_oe_n_q <= 1'h0;
        end else begin
            state_q <= state_d;
            tag_active_q <= tag_active_d;
            bdm_q <= bdm_d;
            enter_q <= enter_d;
            accept_q <= accept_d;
            strobe_q <= strobe_d;
            strobe_oe_n_q <= strobe_oe_n_d;
        end
    end

    // =====================================================
    // head outputs registered
    itg_word_t head_word_q, head_word_d;
    itg_tag_t head_tag_q, head_tag_d;

    always_comb begin
        head_word_d = q_head_word;
        head_tag_d = q_head_tag;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            head_word_q <= `ITG_WORD_RESET;
            head_tag_q <= `ITG_TAG_NONE;
        end else begin
            head_word_q <= head_word_d;
            head_tag_q <= head_tag_d;
        end
    end

    // =====================================================
    // submodules
    itg_tag_sampler u_sampler (
        .clk(clk),
        .sys_rst(sys_rst),
        .external_bus_clock_fall(external_bus_clock_fall),
        .sample_en(tag_active_q),
        .tag_low_input_n(strobe_pin_in),
        .tag_high_input_n(background_pin_in),
        .tag_q(sampled_tag)
    );

    itg_tag_queue u_queue (
        .clk(clk),
        .sys_rst(sys_rst),
        .flush(queue_flush | enter_q),
        .advance(queue_advance),
        .word_in(fetch_word),
        .tag_in(fetch_tag),
        .head_word(q_head_word),
        .head_tag(q_head_tag)
    );

    assign strobe_pin_out = strobe_q;
    assign strobe_pin_oe_n = strobe_oe_n_q;
    assign tag_active = tag_active_q;
    assign serial_cmd_accept = accept_q;
    assign background_debug_mode = bdm_q;
    assign enter_bgnd = enter_q;
    assign head_word = head_word_q;
    assign head_tag = head_tag_q;
endmodule
`default_nettype wire

// File: bench/itg_dev_host.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// development system: bus clock and tag pins
module itg_dev_host (
    input wire logic clk, // system clock
    output logic external_bus_clock_in, // bus clock, idle high
    output logic tag_high_input_n, // high tag level
    output logic tag_low_input_n // low tag level
);
    // bus clock stands still between falls
    initial begin
        external_bus_clock_in = 1'h1;
        tag_high_input_n = 1'h1; // pulled up while released
        tag_low_input_n = 1'h1;
    end
    // one fall; hold sets how slowly the host lets go
    task automatic fall(input logic hi_n, input logic lo_n, input int hold);
        tag_high_input_n = hi_n;
        tag_low_input_n = lo_n;
        @(negedge clk);
        external_bus_clock_in = 1'h0;
        repeat (hold) @(negedge clk);
        external_bus_clock_in = 1'h1;
        tag_high_input_n = 1'h1; // released, pull-up wins
        tag_low_input_n = 1'h1;
    endtask
endmodule
`default_nettype wire

// File: bench/itg_instruction_tagging_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// port checker
module itg_checker (
    input wire logic clk, // tap
    input wire logic sys_rst, // tap
    input wire logic tag_enable_command, // tap
    input wire logic serial_cmd_valid, // tap
    input wire logic low_byte_strobe, // tap
    input wire logic head_execute, // tap
    input wire logic strobe_pin_out, // tap
    input wire logic strobe_pin_oe_n, // tap
    input wire logic tag_active, // tap
    input wire logic serial_cmd_accept, // tap
    input wire logic background_debug_mode, // tap
    input wire logic enter_bgnd, // tap
    input wire itg_pkg::itg_tag_t head_tag // tap
);
    import itg_pkg::*;
    default clocking dc @(posedge clk); endclocking
    default disable iff (sys_rst);
    AST_ARM: assert property (tag_enable_command && !tag_active && !head_execute |=> tag_active)
        else $error("arm command not taken");
    AST_STAY: assert property (!tag_active && !tag_enable_command |=> !tag_active)
        else $error("armed without command");
    AST_OE: assert property (strobe_pin_oe_n == tag_active)
        else $error("strobe drive wrong for tag state");
    // first cycle after reset skipped: past strobe is stale
    AST_STROBE: assert property (!$past(sys_rst) |-> strobe_pin_out == $past(low_byte_strobe))
        else $error("strobe not passed out");
    AST_REFUSE: assert property (serial_cmd_valid && tag_active |=> !serial_cmd_accept)
        else $error("serial command taken while armed");
    AST_PASS: assert property (serial_cmd_valid && !tag_active && !tag_enable_command |=> serial_cmd_accept)
        else $error("serial command lost");
    AST_CAUSE: assert property ($rose(enter_bgnd) |-> $past(head_execute))
        else $error("entry without head execute");
    AST_PULSE: assert property (enter_bgnd |=> !enter_bgnd)
        else $error("entry pulse too long");
    AST_DISARM: assert property (enter_bgnd |-> background_debug_mode && !tag_active)
        else $error("tagging still armed in background");
    AST_FLUSH: assert property (enter_bgnd |-> ##2 head_tag == 2'h0)
        else $error("queue tags kept after entry");
    // main scenarios
    C_ENTRY: cover property (enter_bgnd);
    C_ARMED: cover property ($rose(tag_active));
    C_REFUSE: cover property (serial_cmd_valid && tag_active);
endmodule
bind itg_instruction_tagging itg_checker u_chk (
    .clk(clk),
    .sys_rst(sys_rst),
    .tag_enable_command(tag_enable_command),
    .serial_cmd_valid(serial_cmd_valid),
    .low_byte_strobe(low_byte_strobe),
    .head_execute(head_execute),
    .strobe_pin_out(strobe_pin_out),
    .strobe_pin_oe_n(strobe_pin_oe_n),
    .tag_active(tag_active),
    .serial_cmd_accept(serial_cmd_accept),
    .background_debug_mode(background_debug_mode),
    .enter_bgnd(enter_bgnd),
    .head_tag(head_tag)
);
`default_nettype wire

// File: bench/itg_instruction_tagging_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; $display("wrong value at %0t: %h not %h", $time, a, b); end end
module itg_instruction_tagging_bench;
    import itg_pkg::*;
    // ==========
    // stimulus and observed signals
    logic clk = 0, sys_rst = 1, tag_enable_command = 0, serial_cmd_valid = 0, low_byte_strobe = 0;
    logic queue_advance = 0, queue_flush = 0, break_on_program_control = 0, bkpt_match = 0;
    logic head_execute = 0, bgnd_exit = 0;
    itg_word_t fetch_word = 16'h0000, head_word;
    itg_tag_t head_tag;
    logic strobe_pin_out, strobe_pin_oe_n, tag_active, serial_cmd_accept, background_debug_mode, enter_bgnd;
    wire logic external_bus_clock_in, background_pin_in, lo_drv, strobe_pin_in;
    int error_cnt = 0, tests_run = 0;
    logic [18:0] notes[$]; // {output select, expected}
    logic [18:0] n;
    // shared pin: whoever has the enable owns the level
    assign strobe_pin_in = strobe_pin_oe_n ? lo_drv : strobe_pin_out;
    itg_instruction_tagging DUT (
        .clk(clk),
        .sys_rst(sys_rst),
        .external_bus_clock_in(external_bus_clock_in),
        .tag_enable_command(tag_enable_command),
        .serial_cmd_valid(serial_cmd_valid),
        .strobe_pin_in(strobe_pin_in),
        .background_pin_in(background_pin_in),
        .low_byte_strobe(low_byte_strobe),
        .queue_advance(queue_advance),
        .queue_flush(queue_flush),
        .fetch_word(fetch_word),
        .break_on_program_control(break_on_program_control),
        .bkpt_match(bkpt_match),
        .head_execute(head_execute),
        .bgnd_exit(bgnd_exit),
        .strobe_pin_out(strobe_pin_out),
        .strobe_pin_oe_n(strobe_pin_oe_n),
        .tag_active(tag_active),
        .serial_cmd_accept(serial_cmd_accept),
        .background_debug_mode(background_debug_mode),
        .enter_bgnd(enter_bgnd),
        .head_word(head_word),
        .head_tag(head_tag)
    );
    itg_dev_host p (.clk(clk), .external_bus_clock_in(external_bus_clock_in), .tag_high_input_n(background_pin_in), .tag_low_input_n(lo_drv));
    initial begin
        forever #5 clk = ~clk;
    end
    // core strobe wanders at random
    always @(negedge clk) begin
        low_byte_strobe <= 1'($urandom);
    end
    function automatic itg_word_t obs(input logic [2:0] s);
        case (s)
            3'h0: return {14'h0000, head_tag};
            3'h1: return {15'h0000, tag_active};
            3'h2: return {15'h0000, enter_bgnd};
            3'h3: return {15'h0000, background_debug_mode};
            3'h4: return {15'h0000, serial_cmd_accept};
            3'h5: return {15'h0000, strobe_pin_oe_n};
            default: return head_word;
        endcase
    endfunction
    // ==========
    // watcher: settles 1 ns past the edge, then takes each note
    always @(negedge clk) begin
        #1;
        while (notes.size() > 0) begin
            n = notes.pop_front();
            `CHK(obs(n[18:16]), n[15:0])
        end
    end
    task automatic want(input logic [2:0] s, input logic [1:0] v);
        notes.push_back({s, 14'h0000, v});
    endtask
    task automatic want_word(input itg_word_t w);
        notes.push_back({3'h6, w});
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'h1;
        cyc(1);
        s = 1'h0;
    endtask
    // three advances carry the fetched word to the head
    task automatic adv3();
        itg_word_t first;
        first = 16'h0000;
        for (int i = 0; i < 3; i++) begin
            fetch_word = itg_word_t'($urandom);
            if (i == 0) begin
                first = fetch_word;
            end
            pulse(queue_advance);
            cyc(1);
        end
        cyc(3);
        want_word(first);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ==========
    // hang guard
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        finish_test();
    end
    initial begin
        void'($urandom(39));
        cyc(16);
        sys_rst = 1'h0;
        cyc(1);
        want(3'h1, 2'h0);
        pulse(serial_cmd_valid);
        want(3'h4, 2'h1);
        // every pin code, slow host on later ones
        for (int c = 0; c < 4; c++) begin
            pulse(tag_enable_command);
            want(3'h1, 2'h1);
            want(3'h5, 2'h1);
            pulse(serial_cmd_valid);
            want(3'h4, 2'h0);
            p.fall(c[1], c[0], 1 + c);
            adv3();
            want(3'h0, ~c[1:0]);
            pulse(head_execute);
            want(3'h2, {1'h0, c != 3});
            want(3'h1, {1'h0, c == 3});
            cyc(1);
            want(3'h2, 2'h0);
            want(3'h5, {1'h0, c == 3});
            if (c != 3) begin
                pulse(bgnd_exit);
                want(3'h3, 2'h0);
            end
            pulse(queue_flush);
            $display("tag code %0d done", c);
        end
        // program break rides the tag path, then pins go quiet
        break_on_program_control = 1'h1;
        bkpt_match = 1'h1;
        adv3();
        want(3'h0, 2'h3);
        bkpt_match = 1'h0;
        pulse(head_execute);
        want(3'h3, 2'h1);
        want(3'h1, 2'h0);
        p.fall(1'h0, 1'h0, 1);
        adv3();
        want(3'h0, 2'h0);
        pulse(serial_cmd_valid);
        want(3'h4, 2'h1);
        $display("program break done");
        // program break from idle, tagging never armed
        pulse(bgnd_exit);
        want(3'h3, 2'h0);
        bkpt_match = 1'h1;
        adv3();
        want(3'h0, 2'h3);
        bkpt_match = 1'h0;
        pulse(head_execute);
        want(3'h2, 2'h1);
        want(3'h3, 2'h1);
        $display("idle break done");
        // reset in mid-run clears background state and queue
        sys_rst = 1'h1;
        cyc(2);
        sys_rst = 1'h0;
        cyc(1);
        want(3'h3, 2'h0);
        want(3'h5, 2'h0);
        want(3'h1, 2'h0);
        want(3'h0, 2'h0);
        $display("mid-run reset done");
        cyc(2);
        finish_test();
    end
endmodule
`default_nettype wire
